// File: jisp_pkg.sv
// Constants and types for the JTAG flash programming control block
// Summary of operation
// - Outside modes, only enter/exit instructions act
// - No-op keeps mode, selects default register
// - Address shift selects flash address register
// - Erase prepares erase after address load
// - Read instruction sets up flash verify
// - Read supports explicit address and burst
// - Background entry allows sector access live
// - Background exit leaves background mode
// - Weak pull-up during configuration if set, else tristate
// - Sector-zero-only ignores select, no fallback
// - Otherwise each failed image load switches to the other image
// - Setting picks programming I/O state source
// - Encrypted-only rejects unencrypted image loading
// - Verify-protect and JTAG-secure settings, off
// - Upgrade watchdog enable setting, default on
// - Watchdog timeout setting, default 1FFF
// - Exit after 200 us in Run-Test/Idle
// - Hi-Z entry tristates I/Os until exit
// - Clamp entry drives boundary scan, freezes core
// - Program action happens in Run-Test/Idle
package jisp_pkg;
    localparam int IR_W = 10;
    localparam int DR_W = 32;
    localparam int ADDR_W = 16;
    localparam int WDOG_W = 16;
    localparam logic [IR_W-1:0] INS_HIZ = 10'h2CC;
    localparam logic [IR_W-1:0] INS_CLAMP = 10'h233;
    localparam logic [IR_W-1:0] INS_EXIT = 10'h201;
    localparam logic [IR_W-1:0] INS_PROGRAM = 10'h2F4;
    localparam logic [IR_W-1:0] INS_NOOP = 10'h210;
    localparam logic [IR_W-1:0] INS_ADDR = 10'h203;
    localparam logic [IR_W-1:0] INS_ERASE = 10'h2F2;
    localparam logic [IR_W-1:0] INS_READ = 10'h205;
    localparam logic [IR_W-1:0] background_prog_enter = 10'h199;
    localparam logic [IR_W-1:0] background_prog_exit = 10'h166;
    localparam logic [IR_W-1:0] IR_RESET = 10'h3FF;
    localparam logic [IR_W-1:0] IR_CAPTURE = 10'h001;
    // Exit wait time and its cycle count
    localparam int EXIT_WAIT_US = 200;
    localparam int SYS_CLK_MHZ = 100;
    localparam int EXIT_CYC = EXIT_WAIT_US * SYS_CLK_MHZ;
    // APB byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WDOG = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_ADDR = 8'h0C;
    // Bits of init_config_settings control word
    localparam int B_PULLUP = 0;
    localparam int B_SECT0 = 1;
    localparam int B_ISP_SEC = 2;
    localparam int B_VPROT = 3;
    localparam int B_ENC_ONLY = 4;
    localparam int B_JSECURE = 5;
    localparam int B_WDOG_EN = 6;
    localparam int CTRL_W = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h41;
    localparam logic [WDOG_W-1:0] WDOG_RST = 16'h1FFF;
    // Status word fields
    localparam int S_ISP = 0;
    localparam int S_CLAMP = 1;
    localparam int S_BGP = 2;
    localparam int S_IMG = 3;
    localparam int S_CERR = 4;
    localparam int S_AVALID = 5;
    localparam int S_IR_LSB = 16;
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
        TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
        TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
    } jisp_tap_e;
    typedef enum logic [1:0] {DR_BYP, DR_DEF, DR_ADDR, DR_DATA} jisp_dr_e;
endpackage

// File: jisp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module jisp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic en,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= '0;
            q <= '0;
        end else if (en) begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule

// File: jisp_shreg.sv
// Scan shift register with capture and selectable length
`timescale 1ns/1ps
module jisp_shreg #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic en,
    // Control
    input wire logic cap,
    input wire logic shift,
    input wire logic sin,
    input wire logic [7:0] len,
    input wire logic [W-1:0] cap_val,
    // State
    output logic [W-1:0] q
);
    logic [W-1:0] nxt_q;

    // Serial input enters at the top of the active length
    for (genvar i = 0; i < W; i++) begin : g_bit
        if (i == W - 1) begin : g_top
            assign nxt_q[i] = (8'(i) == len - 8'h01) ? sin : 1'b0;
        end else begin : g_mid
            assign nxt_q[i] = (8'(i) == len - 8'h01) ? sin : q[i+1];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else if (en) begin
            if (cap) begin
                q <= cap_val;
            end else if (shift) begin
                q <= nxt_q;
            end
        end
    end
endmodule

// File: jisp_top.sv
// JTAG flash programming control with stored configuration settings
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module jisp_top #(
    parameter int EXIT_CYC = jisp_pkg::EXIT_CYC
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic CLK_EN,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // JTAG pins
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE_B,
    // Configuration flash port
    output logic [jisp_pkg::ADDR_W-1:0] FLASH_ADDR,
    output logic [jisp_pkg::DR_W-1:0] FLASH_WDATA,
    input wire logic [jisp_pkg::DR_W-1:0] FLASH_RDATA,
    output logic FLASH_RD,
    output logic FLASH_ERASE,
    output logic FLASH_PROG,
    // Configuration loader
    input wire logic CONFIG_START,
    input wire logic CONFIG_BUSY,
    input wire logic IMAGE_FAIL,
    input wire logic IMAGE_ENCRYPTED,
    input wire logic IMAGE_SEL,
    // Mode and setting outputs
    output logic ISP_MODE,
    output logic BGP_MODE,
    output logic IO_TRISTATE,
    output logic IO_WEAK_PULLUP,
    output logic IO_CLAMP,
    output logic CORE_FREEZE,
    output logic BOOT_IMAGE,
    output logic CONFIG_ERROR,
    output logic ISP_DATA_SECONDARY,
    output logic VERIFY_PROTECT,
    output logic JTAG_SECURE,
    output logic WDOG_EN,
    output logic [jisp_pkg::WDOG_W-1:0] WDOG_VALUE
);
    logic tck_s, tms_s, tdi_s, sel_s, tck_d_ff, tck_rise, tck_fall, apb_wr, apb_rd, mapped;
    jisp_pkg::jisp_tap_e tap_ff;
    logic [jisp_pkg::IR_W-1:0] ir_ff, ir_sh;
    logic [jisp_pkg::DR_W-1:0] dr_sh, dr_cap;
    logic isp_ff, clamp_ff, bgp_ff, in_mode, addr_valid_ff, act_done_ff, boot_img_ff, cfg_err_ff;
    jisp_pkg::jisp_dr_e dr_kind;
    logic [7:0] dr_len;
    logic [jisp_pkg::ADDR_W-1:0] addr_ff;
    logic [31:0] exit_cnt_ff;
    logic [jisp_pkg::CTRL_W-1:0] ctrl_ff;
    logic [jisp_pkg::WDOG_W-1:0] wdog_ff;
    logic [31:0] rd_val;
    function automatic logic is_ctl(input logic [jisp_pkg::IR_W-1:0] c);
        is_ctl = (c == jisp_pkg::INS_HIZ) || (c == jisp_pkg::INS_CLAMP) ||
                 (c == jisp_pkg::INS_EXIT) || (c == jisp_pkg::background_prog_enter) ||
                 (c == jisp_pkg::background_prog_exit);
    endfunction
    function automatic logic ins_on(input logic [jisp_pkg::IR_W-1:0] c,
                                    input logic [jisp_pkg::IR_W-1:0] ins, input logic m);
        ins_on = (c == ins) && (m || is_ctl(ins));
    endfunction
    function automatic jisp_pkg::jisp_tap_e tap_next(input jisp_pkg::jisp_tap_e s, input logic t);
        case (s)
            jisp_pkg::TAP_RESET: tap_next = t ? jisp_pkg::TAP_RESET : jisp_pkg::TAP_IDLE;
            jisp_pkg::TAP_IDLE: tap_next = t ? jisp_pkg::TAP_SEL_DR : jisp_pkg::TAP_IDLE;
            jisp_pkg::TAP_SEL_DR: tap_next = t ? jisp_pkg::TAP_SEL_IR : jisp_pkg::TAP_CAP_DR;
            jisp_pkg::TAP_CAP_DR: tap_next = t ? jisp_pkg::TAP_EX1_DR : jisp_pkg::TAP_SH_DR;
            jisp_pkg::TAP_SH_DR: tap_next = t ? jisp_pkg::TAP_EX1_DR : jisp_pkg::TAP_SH_DR;
            jisp_pkg::TAP_EX1_DR: tap_next = t ? jisp_pkg::TAP_UPD_DR : jisp_pkg::TAP_PAU_DR;
            jisp_pkg::TAP_PAU_DR: tap_next = t ? jisp_pkg::TAP_EX2_DR : jisp_pkg::TAP_PAU_DR;
            jisp_pkg::TAP_EX2_DR: tap_next = t ? jisp_pkg::TAP_UPD_DR : jisp_pkg::TAP_SH_DR;
            jisp_pkg::TAP_UPD_DR: tap_next = t ? jisp_pkg::TAP_SEL_DR : jisp_pkg::TAP_IDLE;
            jisp_pkg::TAP_SEL_IR: tap_next = t ? jisp_pkg::TAP_RESET : jisp_pkg::TAP_CAP_IR;
            jisp_pkg::TAP_CAP_IR: tap_next = t ? jisp_pkg::TAP_EX1_IR : jisp_pkg::TAP_SH_IR;
            jisp_pkg::TAP_SH_IR: tap_next = t ? jisp_pkg::TAP_EX1_IR : jisp_pkg::TAP_SH_IR;
            jisp_pkg::TAP_EX1_IR: tap_next = t ? jisp_pkg::TAP_UPD_IR : jisp_pkg::TAP_PAU_IR;
            jisp_pkg::TAP_PAU_IR: tap_next = t ? jisp_pkg::TAP_EX2_IR : jisp_pkg::TAP_PAU_IR;
            jisp_pkg::TAP_EX2_IR: tap_next = t ? jisp_pkg::TAP_UPD_IR : jisp_pkg::TAP_SH_IR;
            jisp_pkg::TAP_UPD_IR: tap_next = t ? jisp_pkg::TAP_SEL_DR : jisp_pkg::TAP_IDLE;
            default: tap_next = jisp_pkg::TAP_RESET;
        endcase
    endfunction
    jisp_sync #(.W(4)) u_sync (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .en(CLK_EN),
        .d({TCK, TMS, TDI, IMAGE_SEL}),
        .q({tck_s, tms_s, tdi_s, sel_s})
    );
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            tck_d_ff <= 1'b0;
            tap_ff <= jisp_pkg::TAP_RESET;
        end else if (CLK_EN) begin
            tck_d_ff <= tck_s;
            if (tck_rise) begin
                tap_ff <= tap_next(tap_ff, tms_s);
            end
        end
    end
    assign tck_rise = CLK_EN & tck_s & ~tck_d_ff;
    assign tck_fall = CLK_EN & ~tck_s & tck_d_ff;
    assign in_mode = isp_ff | bgp_ff;
    jisp_shreg #(.W(jisp_pkg::IR_W)) u_ir (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .en(CLK_EN),
        .cap(tck_rise && tap_ff == jisp_pkg::TAP_CAP_IR),
        .shift(tck_rise && tap_ff == jisp_pkg::TAP_SH_IR),
        .sin(tdi_s),
        .len(8'(jisp_pkg::IR_W)),
        .cap_val(jisp_pkg::IR_CAPTURE),
        .q(ir_sh)
    );
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ir_ff <= jisp_pkg::IR_RESET;
        end else if (CLK_EN && tap_ff == jisp_pkg::TAP_RESET) begin
            ir_ff <= jisp_pkg::IR_RESET;
        end else if (tck_rise && tap_ff == jisp_pkg::TAP_UPD_IR) begin
            ir_ff <= ir_sh;
        end
    end
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            isp_ff <= 1'b0;
            clamp_ff <= 1'b0;
            bgp_ff <= 1'b0;
            exit_cnt_ff <= '0;
        end else if (CLK_EN) begin
            if (tck_rise && tap_ff == jisp_pkg::TAP_UPD_IR) begin
                exit_cnt_ff <= '0;
                if (ir_sh == jisp_pkg::INS_HIZ) begin
                    isp_ff <= 1'b1;
                    clamp_ff <= 1'b0;
                end else if (ir_sh == jisp_pkg::INS_CLAMP) begin
                    isp_ff <= 1'b1;
                    clamp_ff <= 1'b1;
                end else if (ir_sh == jisp_pkg::background_prog_enter) begin
                    bgp_ff <= 1'b1;
                end else if (ir_sh == jisp_pkg::background_prog_exit) begin
                    bgp_ff <= 1'b0;
                end
            end else if (isp_ff && ir_ff == jisp_pkg::INS_EXIT &&
                         tap_ff == jisp_pkg::TAP_IDLE) begin
                if (exit_cnt_ff >= 32'(EXIT_CYC - 1)) begin
                    isp_ff <= 1'b0;
                    clamp_ff <= 1'b0;
                    exit_cnt_ff <= '0;
                end else begin
                    exit_cnt_ff <= exit_cnt_ff + 32'h0000_0001;
                end
            end else begin
                exit_cnt_ff <= '0;
            end
        end
    end
    always_comb begin
        dr_kind = jisp_pkg::DR_BYP;
        dr_len = 8'h01;
        if (ins_on(ir_ff, jisp_pkg::INS_NOOP, in_mode)) begin
            dr_kind = jisp_pkg::DR_DEF;
        end else if (ins_on(ir_ff, jisp_pkg::INS_ADDR, in_mode)) begin
            dr_kind = jisp_pkg::DR_ADDR;
            dr_len = 8'(jisp_pkg::ADDR_W);
        end else if (ins_on(ir_ff, jisp_pkg::INS_READ, in_mode) ||
                     ins_on(ir_ff, jisp_pkg::INS_PROGRAM, in_mode)) begin
            dr_kind = jisp_pkg::DR_DATA;
            dr_len = 8'(jisp_pkg::DR_W);
        end
    end
    always_comb begin
        dr_cap = '0;
        if (dr_kind == jisp_pkg::DR_ADDR) begin
            dr_cap = 32'(addr_ff);
        end else if (dr_kind == jisp_pkg::DR_DATA && ir_ff == jisp_pkg::INS_READ) begin
            dr_cap = FLASH_RDATA;
        end
    end
    jisp_shreg #(.W(jisp_pkg::DR_W)) u_dr (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .en(CLK_EN),
        .cap(tck_rise && tap_ff == jisp_pkg::TAP_CAP_DR),
        .shift(tck_rise && tap_ff == jisp_pkg::TAP_SH_DR),
        .sin(tdi_s),
        .len(dr_len),
        .cap_val(dr_cap),
        .q(dr_sh)
    );
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            addr_ff <= '0;
            addr_valid_ff <= 1'b0;
        end else if (CLK_EN) begin
            if (!in_mode) begin
                addr_valid_ff <= 1'b0;
            end else if (tck_rise && tap_ff == jisp_pkg::TAP_UPD_DR &&
                         dr_kind == jisp_pkg::DR_ADDR) begin
                addr_ff <= dr_sh[jisp_pkg::ADDR_W-1:0];
                addr_valid_ff <= 1'b1;
            end else if (tck_rise && tap_ff == jisp_pkg::TAP_CAP_DR &&
                         dr_kind == jisp_pkg::DR_DATA && ir_ff == jisp_pkg::INS_READ) begin
                addr_ff <= addr_ff + 16'h0001;
            end else if (FLASH_PROG) begin
                addr_ff <= addr_ff + 16'h0001;
            end
        end
    end
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            FLASH_RD <= 1'b0;
            FLASH_PROG <= 1'b0;
            FLASH_ERASE <= 1'b0;
            FLASH_WDATA <= '0;
            act_done_ff <= 1'b0;
        end else if (CLK_EN) begin
            FLASH_RD <= tck_rise && tap_ff == jisp_pkg::TAP_CAP_DR &&
                        dr_kind == jisp_pkg::DR_DATA && ir_ff == jisp_pkg::INS_READ;
            FLASH_PROG <= 1'b0;
            FLASH_ERASE <= 1'b0;
            if (tck_rise && (tap_ff == jisp_pkg::TAP_UPD_DR ||
                             tap_ff == jisp_pkg::TAP_UPD_IR)) begin
                act_done_ff <= 1'b0;
                if (tap_ff == jisp_pkg::TAP_UPD_DR && dr_kind == jisp_pkg::DR_DATA &&
                    ir_ff == jisp_pkg::INS_PROGRAM) begin
                    FLASH_WDATA <= dr_sh;
                end
            end else if (tck_rise && tap_ff == jisp_pkg::TAP_IDLE && !act_done_ff) begin
                act_done_ff <= 1'b1;
                FLASH_PROG <= ins_on(ir_ff, jisp_pkg::INS_PROGRAM, in_mode);
                // Erase without a loaded address would hit a stale sector
                FLASH_ERASE <= ins_on(ir_ff, jisp_pkg::INS_ERASE, in_mode) && addr_valid_ff;
            end
        end
    end
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            TDO <= 1'b0;
            TDO_OE_B <= 1'b1;
        end else if (tck_fall) begin
            TDO <= (tap_ff == jisp_pkg::TAP_SH_IR) ? ir_sh[0] : dr_sh[0];
            TDO_OE_B <= !(tap_ff == jisp_pkg::TAP_SH_IR || tap_ff == jisp_pkg::TAP_SH_DR);
        end
    end
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            boot_img_ff <= 1'b0;
            cfg_err_ff <= 1'b0;
        end else if (CLK_EN) begin
            if (CONFIG_START) begin
                boot_img_ff <= ctrl_ff[jisp_pkg::B_SECT0] ? 1'b0 : sel_s;
                cfg_err_ff <= ctrl_ff[jisp_pkg::B_ENC_ONLY] & ~IMAGE_ENCRYPTED;
            end else if (IMAGE_FAIL && !ctrl_ff[jisp_pkg::B_SECT0]) begin
                boot_img_ff <= ~boot_img_ff;
            end
        end
    end
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            IO_TRISTATE <= 1'b0;
            IO_WEAK_PULLUP <= 1'b0;
            IO_CLAMP <= 1'b0;
            CORE_FREEZE <= 1'b0;
        end else if (CLK_EN) begin
            IO_TRISTATE <= (isp_ff & ~clamp_ff) |
                           (CONFIG_BUSY & ~ctrl_ff[jisp_pkg::B_PULLUP]);
            IO_WEAK_PULLUP <= CONFIG_BUSY & ctrl_ff[jisp_pkg::B_PULLUP];
            IO_CLAMP <= isp_ff & clamp_ff;
            CORE_FREEZE <= isp_ff & clamp_ff;
        end
    end
    assign apb_wr = PSEL & PENABLE & PWRITE & CLK_EN;
    assign apb_rd = PSEL & ~PENABLE & ~PWRITE & CLK_EN;
    assign mapped = (PADDR == jisp_pkg::OFS_CTRL) || (PADDR == jisp_pkg::OFS_WDOG) ||
                    (PADDR == jisp_pkg::OFS_STATUS) || (PADDR == jisp_pkg::OFS_ADDR);
    assign PREADY = 1'b1; // No wait states
    assign PSLVERR = PSEL & PENABLE & ~mapped;
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_ff <= jisp_pkg::CTRL_RST;
            wdog_ff <= jisp_pkg::WDOG_RST;
        end else if (apb_wr) begin
            if (PADDR == jisp_pkg::OFS_CTRL) begin
                ctrl_ff <= PWDATA[jisp_pkg::CTRL_W-1:0];
            end
            if (PADDR == jisp_pkg::OFS_WDOG) begin
                wdog_ff <= PWDATA[jisp_pkg::WDOG_W-1:0];
            end
        end
    end
    always_comb begin
        rd_val = '0;
        case (PADDR)
            jisp_pkg::OFS_CTRL: rd_val = 32'(ctrl_ff);
            jisp_pkg::OFS_WDOG: rd_val = 32'(wdog_ff);
            jisp_pkg::OFS_STATUS: begin
                rd_val[jisp_pkg::S_ISP] = isp_ff;
                rd_val[jisp_pkg::S_CLAMP] = clamp_ff;
                rd_val[jisp_pkg::S_BGP] = bgp_ff;
                rd_val[jisp_pkg::S_IMG] = boot_img_ff;
                rd_val[jisp_pkg::S_CERR] = cfg_err_ff;
                rd_val[jisp_pkg::S_AVALID] = addr_valid_ff;
                rd_val[jisp_pkg::S_IR_LSB +: jisp_pkg::IR_W] = ir_ff;
            end
            jisp_pkg::OFS_ADDR: rd_val = 32'(addr_ff);
            default: rd_val = '0;
        endcase
    end
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PRDATA <= '0;
        end else if (apb_rd) begin
            PRDATA <= rd_val;
        end
    end
    assign ISP_MODE = isp_ff;
    assign BGP_MODE = bgp_ff;
    assign BOOT_IMAGE = boot_img_ff;
    assign CONFIG_ERROR = cfg_err_ff;
    assign FLASH_ADDR = addr_ff;
    assign ISP_DATA_SECONDARY = ctrl_ff[jisp_pkg::B_ISP_SEC];
    assign VERIFY_PROTECT = ctrl_ff[jisp_pkg::B_VPROT];
    assign JTAG_SECURE = ctrl_ff[jisp_pkg::B_JSECURE];
    assign WDOG_EN = ctrl_ff[jisp_pkg::B_WDOG_EN];
    assign WDOG_VALUE = wdog_ff;
endmodule

// File: jisp_top_assertions.sv
// Checker for the flash programming control block
`timescale 1ns/1ps
module jisp_chk #(
    parameter int EXIT_CYC = 50
) (
    // Clock, reset and inputs
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic TMS,
    input wire logic CONFIG_START,
    input wire logic CONFIG_BUSY,
    input wire logic IMAGE_ENCRYPTED,
    // Outputs
    input wire logic FLASH_RD,
    input wire logic FLASH_ERASE,
    input wire logic FLASH_PROG,
    input wire logic ISP_MODE,
    input wire logic BGP_MODE,
    input wire logic IO_WEAK_PULLUP,
    input wire logic IO_CLAMP,
    input wire logic CORE_FREEZE,
    input wire logic CONFIG_ERROR,
    input wire logic JTAG_SECURE,
    input wire logic WDOG_EN,
    input wire logic [jisp_pkg::WDOG_W-1:0] WDOG_VALUE
);
    // Idle needs TMS low, so this bounds idle time
    logic [15:0] low_cnt_ff;
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B)
            low_cnt_ff <= '0;
        else if (TMS)
            low_cnt_ff <= '0;
        else if (low_cnt_ff != 16'hFFFF)
            low_cnt_ff <= low_cnt_ff + 16'h0001;
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    property p_gate; FLASH_RD || FLASH_ERASE || FLASH_PROG |-> ISP_MODE || BGP_MODE; endproperty
    a_gate: assert property (p_gate) else $error("flash pulse outside mode");
    property p_erase; FLASH_ERASE |=> !FLASH_ERASE; endproperty
    a_erase: assert property (p_erase) else $error("erase pulse too long");
    property p_exit; $fell(ISP_MODE) |-> low_cnt_ff >= EXIT_CYC; endproperty
    a_exit: assert property (p_exit) else $error("exit too early");
    property p_clamp; IO_CLAMP |-> ISP_MODE || $past(ISP_MODE); endproperty
    a_clamp: assert property (p_clamp) else $error("clamp outside mode");
    property p_freeze; CORE_FREEZE == IO_CLAMP; endproperty
    a_freeze: assert property (p_freeze) else $error("freeze differs");
    property p_pull; IO_WEAK_PULLUP |-> $past(CONFIG_BUSY); endproperty
    a_pull: assert property (p_pull) else $error("pull-up when idle");
    property p_enc; CONFIG_START && IMAGE_ENCRYPTED |=> !CONFIG_ERROR; endproperty
    a_enc: assert property (p_enc) else $error("error on encrypted");
    property p_rst; $rose(RST_B) |-> WDOG_EN && WDOG_VALUE == 16'h1FFF && !JTAG_SECURE; endproperty
    a_rst: assert property (p_rst) else $error("bad reset setting");
    c_erase: cover property (FLASH_ERASE);
    c_exit: cover property ($fell(ISP_MODE));
    c_clamp: cover property (IO_CLAMP);
endmodule
bind jisp_top jisp_chk #(.EXIT_CYC(EXIT_CYC)) u_chk (.*);

// File: jisp_jtag_host.sv
// JTAG programming host model
`timescale 1ns/1ps
module jisp_jtag_host (
    // Clock
    input wire logic clk,
    // TAP pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    logic tdo_s;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // TCK rests low between frames; TDI flips when unused
    task automatic step(input logic m, input logic d);
        tms <= m;
        tdi <= d;
        repeat (8) @(posedge clk);
        tdo_s = tdo;
        tck <= 1'b1;
        repeat (8) @(posedge clk);
        tck <= 1'b0;
    endtask
    task automatic tap_reset();
        repeat (5) step(1'b1, ~tdi);
        step(1'b0, ~tdi);
    endtask
    // Idle to Shift, LSB first, back to Idle
    task automatic shift(input logic ir, input int n, input logic [31:0] v,
                         output logic [31:0] q);
        q = '0;
        step(1'b1, ~tdi);
        if (ir)
            step(1'b1, ~tdi);
        step(1'b0, ~tdi);
        step(1'b0, ~tdi);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, v[i]);
            q[i] = tdo_s;
        end
        step(1'b1, ~tdi);
        step(1'b0, ~tdi);
    endtask
endmodule

// File: jisp_top_tb.sv
// Self-checking bench for the flash programming control block
`timescale 1ns/1ps
module jisp_top_tb;
    localparam int EXIT_CYC = 50;
    logic SYS_CLK = 1'b0, RST_B = 1'b0, CLK_EN = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
    logic PWRITE = 1'b0, CONFIG_START = 1'b0, CONFIG_BUSY = 1'b0, IMAGE_FAIL = 1'b0;
    logic IMAGE_ENCRYPTED = 1'b1, IMAGE_SEL = 1'b1, err;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0000_0000, PRDATA, FLASH_WDATA, FLASH_RDATA, q;
    logic PREADY, PSLVERR, TCK, TMS, TDI, TDO, TDO_OE_B, FLASH_RD, FLASH_ERASE, FLASH_PROG;
    logic ISP_MODE, BGP_MODE, IO_TRISTATE, IO_WEAK_PULLUP, IO_CLAMP, CORE_FREEZE;
    logic BOOT_IMAGE, CONFIG_ERROR, ISP_DATA_SECONDARY, VERIFY_PROTECT, JTAG_SECURE, WDOG_EN;
    logic [15:0] FLASH_ADDR, WDOG_VALUE;
    int n_errors = 0, compares = 0, cyc = 0, n_erase = 0, n_rd = 0;
    always #5 SYS_CLK = ~SYS_CLK;
    assign FLASH_RDATA = {16'hA5A5, FLASH_ADDR};
    jisp_top #(.EXIT_CYC(EXIT_CYC)) dut (.*);
    jisp_jtag_host host (.clk(SYS_CLK), .tck(TCK), .tms(TMS), .tdi(TDI), .tdo(TDO));
    always @(posedge SYS_CLK) begin
        n_erase += (FLASH_ERASE === 1'b1);
        n_rd += (FLASH_RD === 1'b1);
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            $display("mismatch at %0t: timeout", $time);
            results();
        end
    end
    task automatic cw(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0000_0000);
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        @(posedge SYS_CLK);
        while (PREADY !== 1'b1)
            @(posedge SYS_CLK);
        q = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // Only listed codes are ever loaded
    task automatic ins(input logic [9:0] c);
        host.shift(1'b1, 10, 32'(c), q);
        cw(q, 32'h0000_0001);
        repeat (4) @(posedge SYS_CLK);
    endtask
    task automatic pulse(input logic f);
        @(posedge SYS_CLK);
        {CONFIG_START, IMAGE_FAIL} <= f ? 2'b01 : 2'b10;
        @(posedge SYS_CLK);
        {CONFIG_START, IMAGE_FAIL} <= 2'b00;
        repeat (2) @(posedge SYS_CLK);
    endtask
    task automatic results();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        apb(1'b0, jisp_pkg::OFS_CTRL);
        cw(q, 32'h0000_0041);
        apb(1'b0, jisp_pkg::OFS_WDOG);
        cw(q, 32'h0000_1FFF);
        apb(1'b1, jisp_pkg::OFS_WDOG, 32'h0000_0123);
        @(posedge SYS_CLK) cw(32'(WDOG_VALUE), 32'h0000_0123);
        apb(1'b0, 8'h10);
        cw({q[30:0], err}, 32'h0000_0001);
        $display("test registers done");
        host.tap_reset();
        ins(jisp_pkg::INS_ADDR);
        host.shift(1'b0, 16, 32'h0000_ABCD, q);
        ins(jisp_pkg::INS_ERASE);
        host.step(1'b0, 1'b0);
        cw({FLASH_ADDR, n_erase[15:0]}, 32'h0000_0000);
        ins(jisp_pkg::INS_HIZ);
        cw({ISP_MODE, IO_TRISTATE}, 32'h0000_0003);
        ins(jisp_pkg::INS_ADDR);
        host.shift(1'b0, 16, 32'h0000_0010, q);
        cw(32'(FLASH_ADDR), 32'h0000_0010);
        ins(jisp_pkg::INS_NOOP);
        cw({ISP_MODE, n_erase[15:0]}, 32'h0001_0000);
        ins(jisp_pkg::INS_ERASE);
        host.step(1'b0, 1'b0);
        repeat (6) @(posedge SYS_CLK);
        cw(n_erase, 32'h0000_0001);
        ins(jisp_pkg::INS_READ);
        host.shift(1'b0, 32, 32'h0000_0000, q);
        cw(q, 32'hA5A5_0010);
        host.shift(1'b0, 32, 32'h0000_0000, q);
        cw(q, 32'hA5A5_0011);
        cw(n_rd, 32'h0000_0002);
        ins(jisp_pkg::INS_CLAMP);
        cw({ISP_MODE, IO_CLAMP, CORE_FREEZE}, 32'h0000_0007);
        // Host rests in Idle, TCK stopped, for the exit count
        ins(jisp_pkg::INS_EXIT);
        repeat (EXIT_CYC - 20) @(posedge SYS_CLK);
        cw(32'(ISP_MODE), 32'h0000_0001);
        repeat (30) @(posedge SYS_CLK);
        cw({ISP_MODE, IO_CLAMP}, 32'h0000_0000);
        $display("test isp done");
        ins(jisp_pkg::background_prog_enter);
        ins(jisp_pkg::INS_ADDR);
        host.shift(1'b0, 16, 32'h0000_0020, q);
        cw({BGP_MODE, ISP_MODE, FLASH_ADDR}, 32'h0002_0020);
        pulse(1'b0);
        cw(32'(BGP_MODE), 32'h0000_0001);
        ins(jisp_pkg::background_prog_exit);
        cw(32'(BGP_MODE), 32'h0000_0000);
        $display("test background done");
        CONFIG_BUSY <= 1'b1;
        pulse(1'b0);
        cw({BOOT_IMAGE, CONFIG_ERROR, IO_WEAK_PULLUP}, 32'h0000_0005);
        pulse(1'b1);
        cw(32'(BOOT_IMAGE), 32'h0000_0000);
        apb(1'b1, jisp_pkg::OFS_CTRL, 32'h0000_007E);
        IMAGE_ENCRYPTED <= 1'b0;
        pulse(1'b0);
        cw({BOOT_IMAGE, CONFIG_ERROR}, 32'h0000_0001);
        pulse(1'b1);
        cw({BOOT_IMAGE, IO_TRISTATE, IO_WEAK_PULLUP}, 32'h0000_0002);
        cw({ISP_DATA_SECONDARY, VERIFY_PROTECT, JTAG_SECURE}, 32'h0000_0007);
        $display("test config done");
        results();
    end
endmodule
